//--- pkg/rrt_map.vh
// Purpose: Constants for the register and RAM transfer datapath.
// Assumes: 10-bit instruction words, 4-bit data nibbles.
// Notes:   Opcodes with immediate fields (LXY, LZ, RAM) are compared after masking them.
`ifndef RRT_MAP_VH
`define RRT_MAP_VH

`define RRT_OP_B_TO_A     10'h01e
`define RRT_OP_A_TO_B     10'h00e
`define RRT_OP_Y_TO_A     10'h01f
`define RRT_OP_A_TO_Y     10'h00c
`define RRT_OP_PACK_E     10'h01a
`define RRT_OP_UNPACK_E   10'h02a
`define RRT_OP_A_TO_D     10'h029
`define RRT_OP_D_TO_A     10'h051
`define RRT_OP_Z_TO_A     10'h053
`define RRT_OP_X_TO_A     10'h052
`define RRT_OP_SP_TO_A    10'h050
`define RRT_OP_INC_Y      10'h013
`define RRT_OP_DEC_Y      10'h017
`define RRT_LXY_MASK      10'h300
`define RRT_LXY_VAL       10'h300
`define RRT_LZ_MASK       10'h3fc
`define RRT_LZ_VAL        10'h048
`define RRT_RAM_MASK      10'h3f0
`define RRT_OP_RAM_LOAD   10'h2c0
`define RRT_OP_RAM_SWAP   10'h2d0
`define RRT_OP_RAM_SWAPD  10'h2f0
`define RRT_OP_RAM_SWAPI  10'h2e0
`define RRT_OP_RAM_STORE  10'h2b0
`define RRT_Y_WRAP_INC    4'h0
`define RRT_Y_WRAP_DEC    4'hf

`endif

//--- logic/rrt_y_step.v
// Purpose: Steps register Y up or down modulo 16 and flags the wrap value.
// Assumes: Purely combinational.
// Notes:   Used by increment, decrement and the swap-with-step forms.
`timescale 1ns/1ps
`default_nettype none
`include "rrt_map.vh"

module rrt_y_step (
    // Operand
    input  wire [3:0] y_in,
    input  wire       down,
    // Result
    output wire [3:0] y_out,
    output wire       wrap
);

    assign y_out = down ? (y_in - 4'h1) : (y_in + 4'h1);
    assign wrap  = down ? (y_out == `RRT_Y_WRAP_DEC) : (y_out == `RRT_Y_WRAP_INC);

endmodule // rrt_y_step
`default_nettype wire

//--- logic/rrt_transfer_unit.v
// Purpose: Register, RAM-address and RAM transfer datapath of a 4-bit core.
// Assumes: One instruction per cycle when instr_valid is high; RAM is external.
// Notes:   RAM read data is combinational for the address presented.
`timescale 1ns/1ps
`default_nettype none
`include "rrt_map.vh"

module rrt_transfer_unit (
    // Clock and reset
    input  wire        mclk,
    input  wire        rst_n,
    // Instruction stream
    input  wire        instr_valid,
    input  wire [9:0]  instr,
    // Stack pointer from the sequencer
    input  wire [2:0]  stack_pointer,
    // RAM port addressed by the data pointer
    input  wire [3:0]  ram_rdata,
    output wire [6:0]  data_pointer,
    output reg         ram_we,
    output reg  [3:0]  ram_wdata,
    // Architectural state
    output reg  [3:0]  acc_q,
    output reg  [3:0]  b_q,
    output reg  [3:0]  x_q,
    output reg  [3:0]  y_q,
    output reg  [1:0]  z_q,
    output reg  [2:0]  d_q,
    output reg  [7:0]  e_q,
    // Skip status
    output reg         skip_q
);

    reg  [3:0] acc_d;
    reg  [3:0] b_d;
    reg  [3:0] x_d;
    reg  [3:0] y_d;
    reg  [1:0] z_d;
    reg  [2:0] d_d;
    reg  [7:0] e_d;
    reg        skip_d;
    reg        lxy_q;
    reg        lxy_d;
    wire       step_down;
    wire [3:0] y_next;
    wire       y_wrap;
    wire [3:0] imm_j;
    wire       is_lxy;
    wire       execute;
    wire       hit_b_to_acc;
    wire       hit_acc_to_b;
    wire       hit_y_to_acc;
    wire       hit_acc_to_y;
    wire       hit_pack_e;
    wire       hit_unpack_e;
    wire       hit_acc_to_d;
    wire       hit_d_to_acc;
    wire       hit_z_to_acc;
    wire       hit_x_to_acc;
    wire       hit_sp_to_acc;
    wire       hit_load_z;
    wire       hit_inc_y;
    wire       hit_dec_y;
    wire       hit_ram_load;
    wire       hit_ram_swap;
    wire       hit_ram_swap_dec;
    wire       hit_ram_swap_inc;
    wire       hit_ram_store;
    wire       op_lxy;
    wire       op_b_to_acc;
    wire       op_acc_to_b;
    wire       op_y_to_acc;
    wire       op_acc_to_y;
    wire       op_pack_e;
    wire       op_unpack_e;
    wire       op_acc_to_d;
    wire       op_d_to_acc;
    wire       op_z_to_acc;
    wire       op_x_to_acc;
    wire       op_sp_to_acc;
    wire       op_load_z;
    wire       op_inc_y;
    wire       op_dec_y;
    wire       op_ram_load;
    wire       op_ram_swap;
    wire       op_ram_swap_dec;
    wire       op_ram_swap_inc;
    wire       op_ram_store;
    wire       any_swap;
    wire       any_xor_x;
    wire       any_y_step;
    wire [3:0] x_xor_j;

    // The data pointer is Z, X and the low bit of Y.
    assign data_pointer = {z_q, x_q, y_q[0]};
    assign imm_j   = instr[3:0];
    assign is_lxy  = (instr & `RRT_LXY_MASK) == `RRT_LXY_VAL;
    assign execute = instr_valid && !skip_q && !(is_lxy && lxy_q);

    // Opcode matches, taken before the execute qualifier.
    assign hit_b_to_acc     = (instr == `RRT_OP_B_TO_A);
    assign hit_acc_to_b     = (instr == `RRT_OP_A_TO_B);
    assign hit_y_to_acc     = (instr == `RRT_OP_Y_TO_A);
    assign hit_acc_to_y     = (instr == `RRT_OP_A_TO_Y);
    assign hit_pack_e       = (instr == `RRT_OP_PACK_E);
    assign hit_unpack_e     = (instr == `RRT_OP_UNPACK_E);
    assign hit_acc_to_d     = (instr == `RRT_OP_A_TO_D);
    assign hit_d_to_acc     = (instr == `RRT_OP_D_TO_A);
    assign hit_z_to_acc     = (instr == `RRT_OP_Z_TO_A);
    assign hit_x_to_acc     = (instr == `RRT_OP_X_TO_A);
    assign hit_sp_to_acc    = (instr == `RRT_OP_SP_TO_A);
    assign hit_load_z       = ((instr & `RRT_LZ_MASK) == `RRT_LZ_VAL);
    assign hit_inc_y        = (instr == `RRT_OP_INC_Y);
    assign hit_dec_y        = (instr == `RRT_OP_DEC_Y);
    assign hit_ram_load     = ((instr & `RRT_RAM_MASK) == `RRT_OP_RAM_LOAD);
    assign hit_ram_swap     = ((instr & `RRT_RAM_MASK) == `RRT_OP_RAM_SWAP);
    assign hit_ram_swap_dec = ((instr & `RRT_RAM_MASK) == `RRT_OP_RAM_SWAPD);
    assign hit_ram_swap_inc = ((instr & `RRT_RAM_MASK) == `RRT_OP_RAM_SWAPI);
    assign hit_ram_store    = ((instr & `RRT_RAM_MASK) == `RRT_OP_RAM_STORE);

    // A skipped word or a repeated immediate X/Y load decodes to no operation.
    assign op_lxy           = execute && is_lxy;
    assign op_b_to_acc      = execute && hit_b_to_acc;
    assign op_acc_to_b      = execute && hit_acc_to_b;
    assign op_y_to_acc      = execute && hit_y_to_acc;
    assign op_acc_to_y      = execute && hit_acc_to_y;
    assign op_pack_e        = execute && hit_pack_e;
    assign op_unpack_e      = execute && hit_unpack_e;
    assign op_acc_to_d      = execute && hit_acc_to_d;
    assign op_d_to_acc      = execute && hit_d_to_acc;
    assign op_z_to_acc      = execute && hit_z_to_acc;
    assign op_x_to_acc      = execute && hit_x_to_acc;
    assign op_sp_to_acc     = execute && hit_sp_to_acc;
    assign op_load_z        = execute && hit_load_z;
    assign op_inc_y         = execute && hit_inc_y;
    assign op_dec_y         = execute && hit_dec_y;
    assign op_ram_load      = execute && hit_ram_load;
    assign op_ram_swap      = execute && hit_ram_swap;
    assign op_ram_swap_dec  = execute && hit_ram_swap_dec;
    assign op_ram_swap_inc  = execute && hit_ram_swap_inc;
    assign op_ram_store     = execute && hit_ram_store;

    assign any_swap   = op_ram_swap || op_ram_swap_dec || op_ram_swap_inc;
    assign any_xor_x  = op_ram_load || any_swap || op_ram_store;
    assign any_y_step = op_inc_y || op_dec_y || op_ram_swap_dec || op_ram_swap_inc;
    assign x_xor_j    = x_q ^ imm_j;
    assign step_down  = hit_dec_y || hit_ram_swap_dec;

    rrt_y_step u_y_step (
        .y_in  (y_q),
        .down  (step_down),
        .y_out (y_next),
        .wrap  (y_wrap)
    );

    // Next-value logic, one process per register; skip and the LXY flag share one.
    always @* begin
        acc_d = acc_q;
        if (op_b_to_acc) begin
            acc_d = b_q;
        end else if (op_y_to_acc) begin
            acc_d = y_q;
        end else if (op_unpack_e) begin
            acc_d = e_q[3:0];
        end else if (op_d_to_acc) begin
            acc_d = {1'b0, d_q};
        end else if (op_z_to_acc) begin
            acc_d = {2'b00, z_q};
        end else if (op_x_to_acc) begin
            acc_d = x_q;
        end else if (op_sp_to_acc) begin
            acc_d = {1'b0, stack_pointer};
        end else if (op_ram_load) begin
            acc_d = ram_rdata;
        end else if (any_swap) begin
            acc_d = ram_rdata;
        end
    end

    always @* begin
        b_d = b_q;
        if (op_acc_to_b) begin
            b_d = acc_q;
        end else if (op_unpack_e) begin
            b_d = e_q[7:4];
        end
    end

    always @* begin
        x_d = x_q;
        if (op_lxy) begin
            x_d = instr[7:4];
        end else if (any_xor_x) begin
            x_d = x_xor_j;
        end
    end

    always @* begin
        y_d = y_q;
        if (op_lxy) begin
            y_d = instr[3:0];
        end else if (op_acc_to_y) begin
            y_d = acc_q;
        end else if (any_y_step) begin
            y_d = y_next;
        end
    end

    always @* begin
        z_d = z_q;
        if (op_load_z) begin
            z_d = instr[1:0];
        end
    end

    always @* begin
        d_d = d_q;
        if (op_acc_to_d) begin
            d_d = acc_q[2:0];
        end
    end

    always @* begin
        e_d = e_q;
        if (op_pack_e) begin
            e_d = {b_q, acc_q};
        end
    end

    always @* begin
        skip_d = skip_q;
        lxy_d  = lxy_q;
        if (instr_valid) begin
            skip_d = any_y_step && y_wrap;
            lxy_d  = is_lxy;
        end
    end

    always @* begin
        ram_we    = 1'b0;
        ram_wdata = acc_q;
        if (any_swap || op_ram_store) begin
            ram_we = 1'b1;
        end
    end

    // State registers, cleared by the synchronous reset.
    always @(posedge mclk) begin
        if (!rst_n) begin
            acc_q <= 4'h0;
        end else begin
            acc_q <= acc_d;
        end
    end

    always @(posedge mclk) begin
        if (!rst_n) begin
            b_q <= 4'h0;
        end else begin
            b_q <= b_d;
        end
    end

    always @(posedge mclk) begin
        if (!rst_n) begin
            x_q <= 4'h0;
        end else begin
            x_q <= x_d;
        end
    end

    always @(posedge mclk) begin
        if (!rst_n) begin
            y_q <= 4'h0;
        end else begin
            y_q <= y_d;
        end
    end

    always @(posedge mclk) begin
        if (!rst_n) begin
            z_q <= 2'h0;
        end else begin
            z_q <= z_d;
        end
    end

    always @(posedge mclk) begin
        if (!rst_n) begin
            d_q <= 3'h0;
        end else begin
            d_q <= d_d;
        end
    end

    always @(posedge mclk) begin
        if (!rst_n) begin
            e_q <= 8'h00;
        end else begin
            e_q <= e_d;
        end
    end

    always @(posedge mclk) begin
        if (!rst_n) begin
            skip_q <= 1'b0;
        end else begin
            skip_q <= skip_d;
        end
    end

    always @(posedge mclk) begin
        if (!rst_n) begin
            lxy_q <= 1'b0;
        end else begin
            lxy_q <= lxy_d;
        end
    end

endmodule // rrt_transfer_unit
`default_nettype wire

//--- tb/rrt_transfer_unit_props.sv
// Purpose: Port assertions for the transfer datapath.
// Assumes: Opcodes from rrt_map.vh.
// Notes:   Bound from the testbench top file.
`timescale 1ns/1ps
`default_nettype none
`include "rrt_map.vh"
module rrt_props (
    input wire logic       mclk, rst_n, instr_valid, ram_we, skip_q,
    input wire logic [9:0] instr,
    input wire logic [3:0] ram_rdata, ram_wdata, acc_q, b_q, x_q, y_q,
    input wire logic [7:0] e_q
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    wire logic ex = instr_valid && !skip_q;
    sequence s_swap_cmd; ex && (instr & `RRT_RAM_MASK) == `RRT_OP_RAM_SWAP; endsequence
    property p_b2a; ex && instr == `RRT_OP_B_TO_A |=> acc_q == $past(b_q) && !skip_q; endproperty
    a_b2a: assert property (p_b2a) else $error("b to acc bad");
    property p_a2b; ex && instr == `RRT_OP_A_TO_B |=> b_q == $past(acc_q) && !skip_q; endproperty
    a_a2b: assert property (p_a2b) else $error("acc to b bad");
    property p_pack; ex && instr == `RRT_OP_PACK_E |=> e_q == {$past(b_q), $past(acc_q)}; endproperty
    a_pack: assert property (p_pack) else $error("pack bad");
    property p_unpack; ex && instr == `RRT_OP_UNPACK_E |=> {b_q, acc_q} == $past(e_q); endproperty
    a_unpack: assert property (p_unpack) else $error("unpack bad");
    property p_inc;
        ex && instr == `RRT_OP_INC_Y |=> y_q == $past(y_q) + 4'h1 && skip_q == (y_q == 4'h0);
    endproperty
    a_inc: assert property (p_inc) else $error("inc y bad");
    property p_dec;
        ex && instr == `RRT_OP_DEC_Y |=> y_q == $past(y_q) - 4'h1 && skip_q == (y_q == 4'hf);
    endproperty
    a_dec: assert property (p_dec) else $error("dec y bad");
    property p_swap;
        s_swap_cmd |-> ram_we && ram_wdata == acc_q ##1
            acc_q == $past(ram_rdata) && x_q == ($past(x_q) ^ $past(instr[3:0]));
    endproperty
    a_swap: assert property (p_swap) else $error("swap bad");
    property p_skip;
        instr_valid && skip_q |-> !ram_we ##1 !skip_q && acc_q == $past(acc_q) && y_q == $past(y_q);
    endproperty
    a_skip: assert property (p_skip) else $error("skipped op acted");
endmodule // rrt_props
`default_nettype wire

//--- tb/test_register_ram_transfer_unit.sv
// Purpose: Self-checking bench for the transfer datapath.
// Assumes: Inputs change at the falling edge.
// Notes:   One idle cycle separates instructions.
`timescale 1ns/1ps
`default_nettype none
`include "rrt_map.vh"
module test_register_ram_transfer_unit;
    logic       mclk, rst_n, instr_valid, ram_we, skip_q, we_s;
    logic [9:0] instr;
    logic [2:0] stack_pointer, d_q;
    logic [3:0] ram_rdata, ram_wdata, acc_q, b_q, x_q, y_q, wd_s;
    logic [1:0] z_q;
    logic [7:0] e_q;
    logic [6:0] dp;
    int         err_total = 0, tests_run = 0;
    rrt_transfer_unit dut_u (.mclk(mclk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
        .stack_pointer(stack_pointer), .ram_rdata(ram_rdata), .data_pointer(dp), .ram_we(ram_we),
        .ram_wdata(ram_wdata), .acc_q(acc_q), .b_q(b_q), .x_q(x_q), .y_q(y_q), .z_q(z_q),
        .d_q(d_q), .e_q(e_q), .skip_q(skip_q));
    initial begin mclk = 0; forever #12.5 mclk = ~mclk; end
    task chk(input string n, input [7:0] s, e);
        tests_run++;
        if (s !== e) begin err_total++; $display("wrong value %s exp %h seen %h", n, e, s); end
    endtask
    task op(input [9:0] w, input [3:0] rd);
        @(negedge mclk); instr_valid = 1; instr = w; ram_rdata = rd;
        #1 we_s = ram_we; wd_s = ram_wdata;
        @(negedge mclk); instr_valid = 0; ram_rdata = ~rd;
    endtask
    task stop_test;
        $display("errors %0d checks %0d", err_total, tests_run);
        if (err_total == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task t_moves;
        op(10'h35a, 0); chk("x", x_q, 8'h05); chk("y", y_q, 8'h0a);
        op(`RRT_OP_Y_TO_A, 0); chk("acc", acc_q, 8'h0a);
        op(`RRT_OP_A_TO_B, 0); chk("b", b_q, 8'h0a);
        op(`RRT_OP_SP_TO_A, 0); chk("acc", acc_q, 8'h06);
        op(`RRT_OP_A_TO_Y, 0); chk("y", y_q, 8'h06);
        op(`RRT_OP_PACK_E, 0); chk("e", e_q, 8'ha6);
        op(`RRT_OP_X_TO_A, 0); chk("acc", acc_q, 8'h05);
        op(`RRT_OP_B_TO_A, 0); chk("acc", acc_q, 8'h0a);
        op(`RRT_OP_A_TO_D, 0); chk("d", d_q, 8'h02);
        op(`RRT_OP_UNPACK_E, 0); chk("acc", acc_q, 8'h06); chk("b", b_q, 8'h0a);
        op(`RRT_OP_D_TO_A, 0); chk("acc", acc_q, 8'h02);
        op(10'h04b, 0); op(`RRT_OP_Z_TO_A, 0); chk("acc", acc_q, 8'h03);
        op(10'h312, 0); op(10'h3ab, 0); chk("x", x_q, 8'h01); chk("y", y_q, 8'h02);
        stack_pointer = 3'h7;
        op(`RRT_OP_SP_TO_A, 0); chk("acc", acc_q, 8'h07);
    endtask
    task t_skip;
        op(`RRT_OP_X_TO_A, 0); op(10'h30f, 0);
        op(`RRT_OP_INC_Y, 0); chk("y", y_q, 8'h00); chk("skip", skip_q, 8'h01);
        op(`RRT_OP_A_TO_Y, 0); chk("y", y_q, 8'h00); chk("skip", skip_q, 8'h00);
        op(`RRT_OP_DEC_Y, 0); chk("y", y_q, 8'h0f); chk("skip", skip_q, 8'h01);
        op(`RRT_OP_INC_Y, 0); chk("y", y_q, 8'h0f);
        op(`RRT_OP_DEC_Y, 0); chk("y", y_q, 8'h0e); chk("skip", skip_q, 8'h00);
    endtask
    task t_ram;
        op(`RRT_OP_RAM_SWAP | 10'h5, 4'h9); chk("we", we_s, 8'h01); chk("wd", wd_s, 8'h01);
        chk("acc", acc_q, 8'h09); chk("x", x_q, 8'h05);
        op(`RRT_OP_RAM_LOAD | 10'h3, 4'hc); chk("we", we_s, 8'h00); chk("x", x_q, 8'h06);
        chk("acc", acc_q, 8'h0c);
        op(`RRT_OP_RAM_STORE | 10'h1, 4'h0); chk("wd", wd_s, 8'h0c); chk("x", x_q, 8'h07);
        chk("we", we_s, 8'h01);
        op(`RRT_OP_RAM_SWAPI | 10'h2, 4'h3); chk("y", y_q, 8'h0f); chk("x", x_q, 8'h05);
        chk("dp", dp, 8'h6b);
        op(`RRT_OP_RAM_SWAPI, 4'h4); chk("y", y_q, 8'h00); chk("skip", skip_q, 8'h01);
        op(`RRT_OP_RAM_SWAPD | 10'h1, 4'h7); chk("we", we_s, 8'h00); chk("acc", acc_q, 8'h04);
        op(`RRT_OP_RAM_SWAPD | 10'h1, 4'h7); chk("acc", acc_q, 8'h07); chk("x", x_q, 8'h04);
        chk("y", y_q, 8'h0f); chk("skip", skip_q, 8'h01); chk("wd", wd_s, 8'h04);
    endtask
    initial begin
        instr_valid = 0; instr = 0; ram_rdata = 0; stack_pointer = 3'h6; rst_n = 0;
        repeat (2) @(negedge mclk);
        rst_n = 1;
        t_moves; t_skip; t_ram;
        stop_test;
    end
    initial begin #100000; err_total++; stop_test; end
endmodule // test_register_ram_transfer_unit
bind rrt_transfer_unit rrt_props u_props (.mclk(mclk), .rst_n(rst_n), .instr_valid(instr_valid),
    .ram_we(ram_we), .skip_q(skip_q), .instr(instr), .ram_rdata(ram_rdata),
    .ram_wdata(ram_wdata), .acc_q(acc_q), .b_q(b_q), .x_q(x_q), .y_q(y_q), .e_q(e_q));
`default_nettype wire
